// File: uart_rx_regs.svh
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_RX_STATUS_CTL   8'h00
`define OFS_ADDR_MATCH_CTL  8'h04
`define OFS_LINE_CFG        8'h08
`define OFS_RX_DATA         8'h0C
`define OFS_IRQ_STATUS      8'h10
`define OFS_IRQ_MASK        8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLD_TH_HI           7
`define FLD_TH_LO           6
`define FLD_ADDR_EN         5
`define FLD_IDLE            4
`define FLD_PARITY_ERR_FLAG            3
`define FLD_FRAMING_ERR_FLAG            2
`define FLD_RX_OVERRUN_FLAG            1
`define FLD_AVAIL           0
`define FLD_DIV_LO          16
`define IRQ_THRESH          0
`define IRQ_OVERRUN         1
`define IRQ_FRAMING         2
`define IRQ_PARITY          3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_ADDR_MATCH      16'h0000
`define RST_BAUD_DIV        16'h001A
`define OVS_LAST            4'hF
`define OVS_MID             4'h7
`define BUF_DEPTH           3'h4
`define BUF_3Q              3'h3
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: uart_rx_pkg.sv
package uart_rx_pkg;

  typedef enum logic [1:0] {
    MODE_8N = 2'h0,
    MODE_8E = 2'h1,
    MODE_8O = 2'h2,
    MODE_9N = 2'h3
  } line_mode_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_t;

endpackage : uart_rx_pkg

// File: uart_rx_status.sv
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "uart_rx_regs.svh"

// Functional notes
// - threshold 11: interrupt when buffer becomes full
// - threshold 10: interrupt when buffer holds three
// - threshold 0x: interrupt on every transfer
// - ninth bit set marks an address character
// - address detect only effective in 9-bit mode
// - idle flag high unless receiving a character
// - parity error flag describes head character
// - framing error flag describes head character
// - overrun set when character arrives buffer full
// - clearing overrun empties buffer and shift register
// - data available while buffer holds characters
// - mask bits select compared address bits
// - hardware compares address against match value
module uart_rx_status
  import uart_rx_pkg::*;
(
  input  wire logic        clk_sys_i,     // System clock, 50 MHz
  input  wire logic        rst_n_i,       // Synchronous reset, low
  input  wire logic        rx_i,          // Serial receive pin
  output logic             irq_o,         // Level interrupt
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready   // Read data ready
);
  import uart_rx_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]  thresh_r;
  logic        addr_en_r;
  logic [15:0] addr_ctl_r;
  line_mode_t  mode_r;
  logic [15:0] div_r;
  logic [3:0]  irq_st_r;
  logic [3:0]  irq_mask_r;
  logic        rx_overrun_flag_r;
  logic        rx_meta_r;
  logic        rx_sync_r;
  logic [15:0] baud_cnt_r;
  logic        tick;
  rx_state_t   state_r;
  logic [3:0]  os_r;
  logic [3:0]  bit_r;
  logic [8:0]  shift_r;
  logic        par_err_r;
  logic        done_r;
  logic        framing_err_flag_r;
  logic        matched_r;
  logic [10:0] buf_r [4];
  logic [1:0]  head_r;
  logic [1:0]  tail_r;
  logic [2:0]  count_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        wr_go;
  logic        flush;
  logic        rd_take;
  logic        pop;
  logic        push;
  logic        overrun_ev;
  logic        thresh_ev;
  logic        addr_mode;
  logic        accept;
  logic        addr_hit;
  logic [8:0]  rx_word;
  logic [2:0]  count_nxt;
  logic [31:0] status_word;
  logic [31:0] cfg_word;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic [31:0] wr_old;
  logic        wr_known;
  logic [3:0]  irq_ev;

  // Merge written bytes over the current register image
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // Pin synchroniser and baud tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_i;
      rx_sync_r <= rx_meta_r;
    end
  end

  // Tick runs at sixteen times the bit rate: period is div_r + 1
  assign tick = (baud_cnt_r == 16'h0000);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || tick) begin
      baud_cnt_r <= rst_n_i ? div_r : `RST_BAUD_DIV;
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Receive shift register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    done_r <= 1'b0;
    if (!rst_n_i || flush) begin
      state_r   <= RX_IDLE;
      os_r      <= 4'h0;
      bit_r     <= 4'h0;
      shift_r   <= 9'h000;
      par_err_r <= 1'b0;
      framing_err_flag_r    <= 1'b0;
    end else begin
      unique case (state_r)
        RX_IDLE: begin
          os_r      <= 4'h0;
          par_err_r <= 1'b0;
          if (!rx_sync_r) begin
            state_r <= RX_START;
          end
        end
        RX_START: if (tick) begin
          os_r <= os_r + 4'h1;
          if (os_r == `OVS_MID) begin
            // Glitch shorter than half a bit is not a start bit
            state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
            os_r    <= 4'h0;
            bit_r   <= 4'h0;
          end
        end
        RX_DATA: if (tick) begin
          os_r <= os_r + 4'h1;
          if (os_r == `OVS_LAST) begin
            shift_r <= {rx_sync_r, shift_r[8:1]};
            bit_r   <= bit_r + 4'h1;
            if (bit_r == ((mode_r == MODE_9N) ? 4'h8 : 4'h7)) begin
              state_r <= (mode_r == MODE_8E || mode_r == MODE_8O)
                         ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: if (tick) begin
          os_r <= os_r + 4'h1;
          if (os_r == `OVS_LAST) begin
            par_err_r <= (^shift_r[8:1]) ^ rx_sync_r ^
                         (mode_r == MODE_8O);
            state_r   <= RX_STOP;
          end
        end
        RX_STOP: if (tick) begin
          os_r <= os_r + 4'h1;
          if (os_r == `OVS_LAST) begin
            framing_err_flag_r  <= ~rx_sync_r;
            done_r  <= 1'b1;
            state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address filter
  // ----------------------------------------------------------------
  assign rx_word = (mode_r == MODE_9N) ? shift_r : {1'b0, shift_r[8:1]};
  assign addr_mode = addr_en_r && (mode_r == MODE_9N);
  assign addr_hit = ((rx_word[7:0] ^ addr_ctl_r[7:0]) &
                     addr_ctl_r[15:8]) == 8'h00;
  assign accept = !addr_mode || (rx_word[8] ? addr_hit : matched_r);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !addr_mode) begin
      matched_r <= 1'b0;
    end else if (done_r && rx_word[8]) begin
      matched_r <= addr_hit;
    end
  end

  // ----------------------------------------------------------------
  // Four-character receive buffer
  // ----------------------------------------------------------------
  assign pop  = rd_take && (s_axi_araddr == `OFS_RX_DATA) &&
                (count_r != 3'h0);
  assign overrun_ev = done_r && accept && (count_r == `BUF_DEPTH) && !pop;
  assign push = done_r && accept && !overrun_ev && !flush;
  assign count_nxt = count_r + {2'h0, push} - {2'h0, pop};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_entry
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          buf_r[gi] <= 11'h000;
        end else if (push && tail_r == 2'(gi)) begin
          buf_r[gi] <= {framing_err_flag_r, par_err_r, rx_word};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || flush) begin
      head_r  <= 2'h0;
      tail_r  <= 2'h0;
      count_r <= 3'h0;
    end else begin
      head_r  <= head_r + {1'b0, pop};
      tail_r  <= tail_r + {1'b0, push};
      count_r <= count_nxt;
    end
  end

  always_comb begin
    unique case (thresh_r)
      2'h3:    thresh_ev = push && (count_nxt == `BUF_DEPTH);
      2'h2:    thresh_ev = push && (count_nxt == `BUF_3Q);
      default: thresh_ev = push;
    endcase
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;

  assign status_word = {24'h0, thresh_r, addr_en_r,
                        state_r == RX_IDLE,
                        (count_r != 3'h0) && buf_r[head_r][9],
                        (count_r != 3'h0) && buf_r[head_r][10],
                        rx_overrun_flag_r, count_r != 3'h0};
  assign cfg_word = {div_r, 14'h0, mode_r};

  always_comb begin
    wr_known = 1'b1;
    unique case (awaddr_r)
      `OFS_RX_STATUS_CTL:  wr_old = status_word;
      `OFS_ADDR_MATCH_CTL: wr_old = {16'h0, addr_ctl_r};
      `OFS_LINE_CFG:       wr_old = cfg_word;
      `OFS_RX_DATA:        wr_old = 32'h0;
      `OFS_IRQ_STATUS:     wr_old = 32'h0;
      `OFS_IRQ_MASK:       wr_old = {28'h0, irq_mask_r};
      default: begin
        wr_old   = 32'h0;
        wr_known = 1'b0;
      end
    endcase
  end
  assign wr_val = merge(wr_old, wdata_r, wstrb_r);

  // written zero over a set overrun
  assign flush = wr_go && (awaddr_r == `OFS_RX_STATUS_CTL) &&
                 wstrb_r[0] && rx_overrun_flag_r && !wdata_r[`FLD_RX_OVERRUN_FLAG];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      thresh_r   <= 2'h0;
      addr_en_r  <= 1'b0;
      addr_ctl_r <= `RST_ADDR_MATCH;
      mode_r     <= MODE_8N;
      div_r      <= `RST_BAUD_DIV;
      irq_mask_r <= 4'h0;
    end else if (wr_go) begin
      if (awaddr_r == `OFS_RX_STATUS_CTL) begin
        thresh_r  <= wr_val[`FLD_TH_HI:`FLD_TH_LO];
        addr_en_r <= wr_val[`FLD_ADDR_EN];
      end
      if (awaddr_r == `OFS_ADDR_MATCH_CTL) begin
        addr_ctl_r <= wr_val[15:0];
      end
      if (awaddr_r == `OFS_LINE_CFG) begin
        mode_r <= line_mode_t'(wr_val[1:0]);
        div_r  <= wr_val[31:`FLD_DIV_LO];
      end
      if (awaddr_r == `OFS_IRQ_MASK) begin
        irq_mask_r <= wr_val[3:0];
      end
    end
  end

  // Overrun stays set until software clears it; a new overrun wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_overrun_flag_r <= 1'b0;
    end else if (overrun_ev) begin
      rx_overrun_flag_r <= 1'b1;
    end else if (flush) begin
      rx_overrun_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign irq_ev = {push && par_err_r, push && framing_err_flag_r, overrun_ev, thresh_ev};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_st_r <= 4'h0;
    end else if (wr_go && awaddr_r == `OFS_IRQ_STATUS && wstrb_r[0]) begin
      irq_st_r <= (irq_st_r & ~wdata_r[3:0]) | irq_ev;
    end else begin
      irq_st_r <= irq_st_r | irq_ev;
    end
  end

  assign irq_o = |(irq_st_r & irq_mask_r);

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;
  assign rd_take       = s_axi_arvalid && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // Reading the data word pops the head character
  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'h0})
      `OFS_RX_STATUS_CTL:  rd_mux = status_word;
      `OFS_ADDR_MATCH_CTL: rd_mux = {16'h0, addr_ctl_r};
      `OFS_LINE_CFG:       rd_mux = cfg_word;
      `OFS_RX_DATA:        rd_mux = {21'h0, buf_r[head_r]};
      `OFS_IRQ_STATUS:     rd_mux = {28'h0, irq_st_r};
      `OFS_IRQ_MASK:       rd_mux = {28'h0, irq_mask_r};
      default:             rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= (s_axi_araddr[7:2] > 6'h05) ? 32'h0 : rd_mux;
      rresp_r  <= (s_axi_araddr[7:2] > 6'h05) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : uart_rx_status

// File: uart_rx_status_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Bus handshake and status checks
// ----------------------------------------------------------
module uart_rx_status_monitor (
  input wire logic        clk_sys_i,     // Clock
  input wire logic        rst_n_i,       // Reset, low
  input wire logic        s_axi_awvalid, // AW valid
  input wire logic        s_axi_awready, // AW ready
  input wire logic        s_axi_wvalid,  // W valid
  input wire logic        s_axi_wready,  // W ready
  input wire logic [1:0]  s_axi_bresp,   // B resp
  input wire logic        s_axi_bvalid,  // B valid
  input wire logic        s_axi_bready,  // B ready
  input wire logic [7:0]  s_axi_araddr,  // AR addr
  input wire logic        s_axi_arvalid, // AR valid
  input wire logic        s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata,   // R data
  input wire logic [1:0]  s_axi_rresp,   // R resp
  input wire logic        s_axi_rvalid,  // R valid
  input wire logic        s_axi_rready   // R ready
);
  logic [7:0] rd_addr_r;
  // Offset of the read in flight, to know what rdata means
  always_ff @(posedge clk_sys_i) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_r <= s_axi_araddr;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_empty_no_err: assert property (
    $rose(s_axi_rvalid) && rd_addr_r[7:2] == 6'h0 && !s_axi_rdata[0]
    |-> s_axi_rdata[3:2] == 2'h0)
    else $error("error flags set with empty buffer");
endmodule : uart_rx_status_monitor

bind uart_rx_status uart_rx_status_monitor mon_u (.clk_sys_i, .rst_n_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);

// File: uart_tx_model.sv
`timescale 1ns/1ps
module uart_tx_model (
  input  wire logic clk_sys_i, // Clock
  output logic      line_o     // Serial line, idle high
);
  initial line_o = 1'b1;
  // One bit lasts 16 clocks, matching a divisor of zero
  task automatic put_bit(input logic b);
    line_o <= b;
    repeat (16) @(posedge clk_sys_i);
  endtask : put_bit
  // par: 0 none, 1 even, 2 odd; bad_* corrupt one field
  task automatic send(input logic [8:0] d, input int nb, input int par,
                      input logic bad_par, input logic bad_stop);
    logic p;
    p = ^d[7:0] ^ (par == 2) ^ bad_par;
    @(posedge clk_sys_i);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++) put_bit(d[i]);
    if (par != 0) put_bit(p);
    put_bit(~bad_stop);
    line_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : send
endmodule : uart_tx_model

// File: uart_rx_status_addr_detect_bench.sv
`timescale 1ns/1ps
module uart_rx_status_addr_detect_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  wire logic   rx_i;
  logic        irq_o;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [31:0] seed = 32'h00002420;
  logic [10:0] q[$];
  logic [1:0]  th_m = 2'h0;
  logic        en_m = 1'b0;
  logic        ovr_m = 1'b0;
  int          fails = 0;
  int          num_checks = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  uart_rx_status dut_u (.clk_sys_i, .rst_n_i, .rx_i, .irq_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  uart_tx_model tx_u (.clk_sys_i, .line_o(rx_i));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] st_exp(input logic idle);
    logic [10:0] h;
    h = (q.size() != 0) ? q[0] : 11'h000;
    return {24'h0, th_m, en_m, idle, h[9], h[10], ovr_m, q.size() != 0};
  endfunction : st_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_sys_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_sys_i);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys_i);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask : rd

  // The irq line is combinational, so look at it mid-cycle
  task automatic irq_chk(input logic e);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, {31'h0, e});
    @(posedge clk_sys_i);
  endtask : irq_chk

  task automatic tx(input logic [8:0] d, input int nb, input int par,
                    input logic bp, input logic bs, input logic keep);
    tx_u.send(d, nb, par, bp, bs);
    if (keep && q.size() == 4) ovr_m = 1'b1;
    else if (keep) q.push_back({bs, bp, d});
  endtask : tx

  task automatic drain();
    while (q.size() != 0) begin
      rd(8'h00);
      chk(rdat, st_exp(1'b1));
      rd(8'h0C);
      chk(rdat, {21'h0, q.pop_front()});
    end
    rd(8'h00);
    chk(rdat, st_exp(1'b1));
  endtask : drain

  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(8'h00);
    chk(rdat, st_exp(1'b1));
    rd(8'h04);
    chk(rdat, 32'h0);
    rd(8'h08);
    chk(rdat, 32'h001A0000);
    rd(8'h18);
    chk({30'h0, resp}, 32'h2);
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h1);
    chk({30'h0, resp}, 32'h0);
    wr(8'h18, 32'h0);
    chk({30'h0, resp}, 32'h2);
    s_axi_wstrb <= 4'h2;
    wr(8'h04, 32'h0000F0A5);
    s_axi_wstrb <= 4'hF;
    rd(8'h04);
    chk(rdat, 32'h0000F000);
    for (int th = 0; th < 4; th++) begin
      th_m = th[1:0];
      wr(8'h00, {24'h0, th_m, 6'h0});
      wr(8'h10, 32'hF);
      for (int k = 1; k <= 4; k++) begin
        logic [31:0] rv;
        rv = xs();
        tx({1'b0, rv[7:0]}, 8, 0, 1'b0, 1'b0, 1'b1);
        rd(8'h10);
        chk(rdat, {31'h0, th < 2 || k == th + 1});
        irq_chk(th < 2 || k == th + 1);
        wr(8'h10, 32'h1);
      end
      drain();
    end
    th_m = 2'h0;
    wr(8'h00, 32'h0);
    wr(8'h10, 32'hF);
    for (int k = 0; k < 5; k++) tx(9'h0C3, 8, 0, 1'b0, 1'b0, 1'b1);
    rd(8'h00);
    chk(rdat, st_exp(1'b1));
    rd(8'h10);
    chk(rdat, 32'h3);
    wr(8'h14, 32'h2);
    irq_chk(1'b1);
    wr(8'h14, 32'h0);
    irq_chk(1'b0);
    wr(8'h00, 32'h0);
    ovr_m = 1'b0;
    q.delete();
    drain();
    fork
      tx(9'h069, 8, 0, 1'b0, 1'b0, 1'b1);
      begin
        repeat (40) @(posedge clk_sys_i);
        rd(8'h00);
        chk(rdat, st_exp(1'b0));
      end
    join
    drain();
    wr(8'h08, 32'h1);
    wr(8'h10, 32'hF);
    tx(9'h0A5, 8, 1, 1'b1, 1'b0, 1'b1);
    tx(9'h03C, 8, 1, 1'b0, 1'b0, 1'b1);
    tx(9'h05A, 8, 1, 1'b0, 1'b1, 1'b1);
    rd(8'h10);
    chk(rdat, 32'hD);
    drain();
    wr(8'h08, 32'h2);
    tx(9'h081, 8, 2, 1'b0, 1'b0, 1'b1);
    drain();
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h0000F0A5);
    en_m = 1'b1;
    wr(8'h00, 32'h20);
    tx(9'h055, 9, 0, 1'b0, 1'b0, 1'b0);
    tx(9'h1A7, 9, 0, 1'b0, 1'b0, 1'b1);
    tx(9'h033, 9, 0, 1'b0, 1'b0, 1'b1);
    tx(9'h1B5, 9, 0, 1'b0, 1'b0, 1'b0);
    tx(9'h044, 9, 0, 1'b0, 1'b0, 1'b0);
    drain();
    wr(8'h08, 32'h0);
    tx(9'h0E1, 8, 0, 1'b0, 1'b0, 1'b1);
    drain();
    tally_and_finish();
  end
endmodule : uart_rx_status_addr_detect_bench
